// *** hw/fap_host_ctrl.sv ***
// Host controller that reads identification and protection data from a parallel flash.
module fap_host_ctrl #(
   parameter int ACC_CYC = fap_pkg::ACCESS_CYC,
   parameter int WR_CYC = fap_pkg::WE_CYC
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [fap_pkg::FDATA_W-1:0] dqIn,
   output fap_pkg::fap_pins_s flashPins,
   output logic hvIdLevel,
   output logic hvResetLevel
);
   import fap_pkg::*;

   // Elaboration check: a read strobe under eight cycles or a write strobe under one cycle is refused.
   if (ACC_CYC < 8 || WR_CYC < 1) begin : gBadCyc
      $error("fap_host_ctrl: strobe lengths out of range");
   end

   // Address A3..A0 pattern that selects one identification item.
   function automatic logic [3:0] itemSelect(input fap_item_e item);
      logic [3:0] sel;
      sel = SEL_MANUF;
      unique case (item)
         ITEM_DEV1: sel = SEL_DEV1;
         ITEM_DEV2: sel = SEL_DEV2;
         ITEM_DEV3: sel = SEL_DEV3;
         ITEM_PROT: sel = SEL_PROT;
         ITEM_SECURE: sel = SEL_SECURE;
         default: sel = SEL_MANUF;
      endcase
      return sel;
   endfunction

   // Full request address for an identification read; A-1 and A6 stay low.
   function automatic logic [REQ_ADDR_W-1:0] idAddress(input fap_item_e item,
                                                      input logic [REQ_ADDR_W-1:0] sect);
      logic [REQ_ADDR_W-1:0] a;
      a = '0;
      a[4:1] = itemSelect(item);
      a[ID_SELECT_PIN+1] = 1'b0;
      if (item == ITEM_PROT) begin
         // One address anywhere in a group answers for all four sectors of it.
         a[REQ_ADDR_W-1:SECTOR_LO_PIN+1] = sect[REQ_ADDR_W-1:SECTOR_LO_PIN+1];
      end
      return a;
   endfunction

   logic wrPend_q;
   logic [7:0] wrOfs_q;
   fap_op_e op_q;
   fap_item_e item_q;
   logic hvId_q;
   logic hvRst_q;
   logic byte_q;
   logic [REQ_ADDR_W-1:0] addr_q;
   logic [FDATA_W-1:0] wdata_q;
   logic [FDATA_W-1:0] rdata_q;
   logic busy_q;
   logic start_q;
   logic prot_q;
   logic lock_q;
   fap_req_s req;
   logic [FDATA_W-1:0] cycData;
   logic cycDone;
   logic [31:0] statusWord;
   logic [31:0] ctrlWord;
   logic ctrlWr;

   assign ctrlWr = wrPend_q && wrOfs_q == OFS_CTRL;
   assign statusWord = {29'h0, lock_q, prot_q, busy_q};
   assign ctrlWord = {21'h0, item_q, 1'b0, byte_q, hvRst_q, hvId_q, 1'b0, op_q, 1'b0};

   // Request toward the cycle engine; identification reads build their own address.
   always_comb begin
      req.isWrite = (op_q == OP_WRITE);
      req.byteMode = byte_q;
      req.wdata = wdata_q;
      req.addr = (op_q == OP_ID) ? idAddress(item_q, addr_q) : addr_q;
   end

   // AHB-Lite slave answers with no wait states and always OKAY.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wrPend_q <= 1'b0;
         wrOfs_q <= 8'h00;
         hrdata <= 32'h0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wrPend_q <= hsel && htrans[1] && hready && hwrite;
         wrOfs_q <= haddr[7:0];
         if (hsel && htrans[1] && hready && !hwrite) begin
            unique case (haddr[7:0])
               OFS_CTRL: hrdata <= ctrlWord;
               OFS_ADDR: hrdata <= {10'h0, addr_q};
               OFS_WDATA: hrdata <= {16'h0, wdata_q};
               OFS_RDATA: hrdata <= {16'h0, rdata_q};
               OFS_STATUS: hrdata <= statusWord;
               default: hrdata <= 32'h0;
            endcase
         end
      end
   end

   // Software-written configuration; the word size is unused because only words occur.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         op_q <= OP_ID;
         item_q <= ITEM_MANUF;
         hvId_q <= 1'b0;
         hvRst_q <= 1'b0;
         byte_q <= 1'b0;
         addr_q <= '0;
         wdata_q <= '0;
      end else if (wrPend_q) begin
         if (wrOfs_q == OFS_CTRL) begin
            op_q <= fap_op_e'(hwdata[CTRL_OP_LO+:2]);
            item_q <= fap_item_e'(hwdata[CTRL_ITEM_LO+:3]);
            hvId_q <= hwdata[CTRL_HV_ID];
            hvRst_q <= hwdata[CTRL_HV_RST];
            byte_q <= hwdata[CTRL_BYTE];
         end
         if (wrOfs_q == OFS_ADDR) begin
            addr_q <= hwdata[REQ_ADDR_W-1:0];
         end
         if (wrOfs_q == OFS_WDATA) begin
            wdata_q <= hwdata[FDATA_W-1:0];
         end
      end
   end

   // High-voltage levels follow the control bits and stay as long as software holds them.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         hvIdLevel <= 1'b0;
         hvResetLevel <= 1'b0;
      end else begin
         hvIdLevel <= hvId_q;
         hvResetLevel <= hvRst_q;
      end
   end

   // Start is refused while a cycle runs; a reserved op code never starts.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         start_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         start_q <= ctrlWr && hwdata[CTRL_START] && !busy_q && !start_q &&
                    hwdata[CTRL_OP_LO+:2] != OP_RSVD;
         if (start_q) begin
            busy_q <= 1'b1;
         end else if (cycDone) begin
            busy_q <= 1'b0;
         end
      end
   end

   // Result capture and decoded protection and lock flags.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= '0;
         prot_q <= 1'b0;
         lock_q <= 1'b0;
      end else if (cycDone && op_q != OP_WRITE) begin
         rdata_q <= cycData;
         if (op_q == OP_ID && item_q == ITEM_PROT) begin
            prot_q <= cycData[PROT_BIT];
         end
         if (op_q == OP_ID && item_q == ITEM_SECURE) begin
            lock_q <= cycData[LOCK_BIT];
         end
      end
   end

   fap_bus_cycle #(
      .ACC_CYC(ACC_CYC),
      .WR_CYC(WR_CYC)
   ) u_cycle (
      .core_clk(core_clk),
      .resetn(resetn),
      .start(start_q),
      .req(req),
      .dqIn(dqIn),
      .pins(flashPins),
      .rdata(cycData),
      .done(cycDone)
   );

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   sequence seqIdStart;
      start_q && op_q == OP_ID;
   endsequence

   sequence seqProtDone;
      cycDone && op_q == OP_ID && item_q == ITEM_PROT;
   endsequence

   AST_ID_A6_LOW: assert property (seqIdStart |=> flashPins.addr[ID_SELECT_PIN] == 1'b0)
      else $error("A6 not low on identification read");
   AST_ID_ITEM: assert property (seqIdStart |=> flashPins.addr[3:0] == itemSelect(item_q))
      else $error("wrong item select on A3..A0");
   AST_PROT_FLAG: assert property (seqProtDone |=> prot_q == $past(cycData[PROT_BIT]))
      else $error("protection flag not taken from bit zero");
   AST_HV_ID_HELD: assert property ((seqIdStart and hvId_q) ##2 !flashPins.oeN |-> hvIdLevel)
      else $error("identification strobe without high voltage level");
   AST_BUSY_SPAN: assert property (start_q |=> busy_q ##[1:40] !busy_q)
      else $error("busy did not clear after cycle");

endmodule

// *** hw/fap_pkg.sv ***
// Package for the flash identification and group protection host controller.
package fap_pkg;

   // Register byte offsets on the AHB-Lite slave.
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_ADDR = 8'h04;
   localparam logic [7:0] OFS_WDATA = 8'h08;
   localparam logic [7:0] OFS_RDATA = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;

   // Control register field positions.
   localparam int CTRL_START = 0;
   localparam int CTRL_OP_LO = 1;
   localparam int CTRL_HV_ID = 4;
   localparam int CTRL_HV_RST = 5;
   localparam int CTRL_BYTE = 6;
   localparam int CTRL_ITEM_LO = 8;

   // Status register field positions.
   localparam int ST_BUSY = 0;
   localparam int ST_PROT = 1;
   localparam int ST_LOCK = 2;

   // Flash pin geometry: A20..A0, plus A-1 carried on the top data pin in byte mode.
   localparam int FADDR_W = 21;
   localparam int FDATA_W = 16;
   localparam int REQ_ADDR_W = FADDR_W + 1;
   localparam int ID_SELECT_PIN = 6;
   localparam int SECTOR_LO_PIN = 12;
   localparam int LOW_MINUS1 = 15;

   // Identification data bit meanings.
   localparam int PROT_BIT = 0;
   localparam int LOCK_BIT = 7;

   // Identification item selectors on A3..A0.
   localparam logic [3:0] SEL_MANUF = 4'h0;
   localparam logic [3:0] SEL_DEV1 = 4'h1;
   localparam logic [3:0] SEL_DEV2 = 4'he;
   localparam logic [3:0] SEL_DEV3 = 4'hf;
   localparam logic [3:0] SEL_PROT = 4'h2;
   localparam logic [3:0] SEL_SECURE = 4'h3;

   // Bus cycle timing at the 125 MHz core clock.
   localparam int CLK_PERIOD_NS = 8;
   localparam int ACCESS_NS = 90;
   localparam int WE_PULSE_NS = 35;
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WE_CYC = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {OP_ID, OP_READ, OP_WRITE, OP_RSVD} fap_op_e;
   typedef enum logic [2:0] {ITEM_MANUF, ITEM_DEV1, ITEM_DEV2, ITEM_DEV3, ITEM_PROT,
                             ITEM_SECURE, ITEM_R6, ITEM_R7} fap_item_e;

   // One flash bus cycle request.
   typedef struct packed {
      logic isWrite;
      logic byteMode;
      logic [REQ_ADDR_W-1:0] addr;
      logic [FDATA_W-1:0] wdata;
   } fap_req_s;

   // Flash pins driven by the controller; strobes are active low.
   typedef struct packed {
      logic ceN;
      logic oeN;
      logic weN;
      logic byteN;
      logic [FADDR_W-1:0] addr;
      logic [FDATA_W-1:0] dqOut;
      logic [FDATA_W-1:0] dqOe;
   } fap_pins_s;

   localparam fap_pins_s PINS_IDLE = '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, byteN: 1'b1,
                                      addr: '0, dqOut: '0, dqOe: '0};

endpackage

// *** hw/fap_bus_cycle.sv ***
// One asynchronous flash read or write cycle, timed in core clock cycles.
module fap_bus_cycle #(
   parameter int ACC_CYC = fap_pkg::ACCESS_CYC,
   parameter int WR_CYC = fap_pkg::WE_CYC
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic start,
   input wire fap_pkg::fap_req_s req,
   input wire logic [fap_pkg::FDATA_W-1:0] dqIn,
   output fap_pkg::fap_pins_s pins,
   output logic [fap_pkg::FDATA_W-1:0] rdata,
   output logic done
);
   import fap_pkg::*;

   localparam int MAX_CYC = ACC_CYC + 4;

   // Elaboration check: the strobe counter is eight bits wide, so longer strobes cannot be served.
   if (ACC_CYC < 8 || WR_CYC < 1 || ACC_CYC > 255 || WR_CYC > 255) begin : gBadCyc
      $error("fap_bus_cycle: strobe lengths out of range");
   end

   typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_STROBE, CY_HOLD} fap_cyc_e;

   fap_cyc_e state_q;
   logic [7:0] count_q;
   logic wr_q;
   logic byte_q;

   // Cycle sequencer: address settles one cycle before the strobe falls.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= CY_IDLE;
         count_q <= 8'h00;
         wr_q <= 1'b0;
         byte_q <= 1'b0;
      end else begin
         unique case (state_q)
            CY_IDLE: begin
               if (start) begin
                  state_q <= CY_SETUP;
                  wr_q <= req.isWrite;
                  byte_q <= req.byteMode;
                  count_q <= req.isWrite ? 8'(WR_CYC - 1) : 8'(ACC_CYC - 1);
               end
            end
            CY_SETUP: state_q <= CY_STROBE;
            CY_STROBE: begin
               if (count_q == 8'h00) begin
                  state_q <= CY_HOLD;
               end else begin
                  count_q <= count_q - 8'h01;
               end
            end
            CY_HOLD: state_q <= CY_IDLE;
         endcase
      end
   end

   // Pin drive; write enable and output enable are never low together.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pins <= PINS_IDLE;
      end else begin
         unique case (state_q)
            CY_IDLE: begin
               if (start) begin
                  pins.ceN <= 1'b0;
                  pins.byteN <= !req.byteMode;
                  pins.addr <= req.addr[REQ_ADDR_W-1:1];
                  pins.dqOut <= req.wdata;
                  pins.dqOe <= '0;
                  if (req.isWrite) begin
                     pins.dqOe[7:0] <= 8'hff;
                     pins.dqOe[LOW_MINUS1-1:8] <= {7{!req.byteMode}};
                     pins.dqOe[LOW_MINUS1] <= 1'b1;
                  end
                  // In byte mode the top data pin carries A-1 for the whole cycle.
                  if (req.byteMode) begin
                     pins.dqOut[LOW_MINUS1] <= req.addr[0];
                     pins.dqOe[LOW_MINUS1] <= 1'b1;
                  end
               end
            end
            CY_SETUP: begin
               if (wr_q) begin
                  pins.weN <= 1'b0;
               end else begin
                  pins.oeN <= 1'b0;
               end
            end
            CY_STROBE: begin
               if (count_q == 8'h00) begin
                  pins.weN <= 1'b1;
                  pins.oeN <= 1'b1;
               end
            end
            CY_HOLD: begin
               pins.ceN <= 1'b1;
               pins.dqOe <= '0;
            end
         endcase
      end
   end

   // Read data is taken on the last strobe cycle; the upper byte is not valid in byte mode.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rdata <= '0;
      end else if (state_q == CY_STROBE && count_q == 8'h00 && !wr_q) begin
         rdata <= byte_q ? {8'h00, dqIn[7:0]} : dqIn;
      end
   end

   // Completion pulse, one cycle, as chip enable rises.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         done <= 1'b0;
      end else begin
         done <= (state_q == CY_HOLD);
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   sequence seqOeFall;
      $fell(pins.oeN);
   endsequence

   sequence seqOeHeld;
      !pins.oeN[*8];
   endsequence

   AST_STROBE_EXCL: assert property (!(!pins.weN && !pins.oeN))
      else $error("write and output enable low together");
   AST_OE_WIDTH: assert property (seqOeFall |-> seqOeHeld ##1 !pins.ceN)
      else $error("output enable pulse too short");
   AST_DONE_BOUND: assert property (state_q == CY_IDLE && start |-> ##[1:MAX_CYC] done)
      else $error("bus cycle did not finish in time");
   AST_WRITE_DRIVES: assert property (!pins.weN |-> pins.dqOe[7:0] == 8'hff && pins.oeN)
      else $error("write without data drive");
   AST_BYTE_A1: assert property (!pins.ceN && !pins.byteN |-> pins.dqOe[LOW_MINUS1])
      else $error("A-1 not driven in byte mode");

endmodule

// *** bench/fap_flash_model.sv ***
// Behavioural parallel flash with identification, group protection and a small array.
module fap_flash_model
   import fap_pkg::*;
#(
   parameter logic [7:0] MANUF_CODE = 8'h5c, // Arbitrary identity value.
   parameter logic [7:0] DEV1_CODE = 8'h3d, // Arbitrary identity value.
   parameter logic [7:0] DEV2_CODE = 8'h47, // Arbitrary identity value.
   parameter logic [7:0] DEV3_CODE = 8'h29, // Arbitrary identity value.
   parameter logic [7:0] UPPER_CODE = 8'h6b, // Arbitrary identity value.
   parameter logic TOP_BOOT = 1'b1,
   parameter logic LOCKED = 1'b1
) (
   input wire fap_pkg::fap_pins_s pins,
   input wire logic hvIdLevel,
   input wire logic hvResetLevel,
   output logic [15:0] dqIn,
   output logic [20:0] lastAddr,
   output logic lastHv
);
   logic [15:0] mem [int];
   logic prot [16];
   logic cmdId;
   logic [15:0] rdVal;
   logic [15:0] lastDrv;
   logic [15:0] word;
   wire idMode = hvIdLevel || cmdId;
   wire byteM = !pins.byteN;
   wire drive = !pins.ceN && !pins.oeN && pins.weN;

   // Every group starts unprotected and the model leaves identification mode.
   initial begin
      foreach (prot[i]) prot[i] = 1'b0;
      cmdId = 1'b0;
      lastDrv = 16'h0;
   end

   // Read value; the group of a sector is A20..A17, so four 64 KB sectors share it.
   always @* begin
      word = mem.exists(int'(pins.addr)) ? mem[int'(pins.addr)] : 16'hffff;
      rdVal = byteM ? {8'h00, (pins.dqOut[15] ? word[15:8] : word[7:0])} : word;
      if (idMode && !pins.addr[6]) begin
         case (pins.addr[3:0])
            4'h0: rdVal = {UPPER_CODE, MANUF_CODE};
            4'h1: rdVal = {UPPER_CODE, DEV1_CODE};
            4'he: rdVal = {UPPER_CODE, DEV2_CODE};
            4'hf: rdVal = {UPPER_CODE, DEV3_CODE};
            4'h2: rdVal = {15'h0, prot[pins.addr[20:17]]};
            4'h3: rdVal = {8'h00, LOCKED, 2'b00, TOP_BOOT, 4'h8};
            default: rdVal = 16'hffff;
         endcase
      end
   end

   // Resolved data wire; a released bit shows the inverse of its last value.
   always @* begin
      for (int i = 0; i < 16; i++) begin
         if (pins.dqOe[i]) dqIn[i] = pins.dqOut[i];
         else if (drive && !(byteM && i > 7)) dqIn[i] = rdVal[i];
         else dqIn[i] = ~lastDrv[i];
      end
   end

   // Remember what the last read showed and where it pointed.
   always @(posedge pins.oeN) begin
      lastDrv = dqIn;
      lastAddr = pins.addr;
      lastHv = hvIdLevel;
   end

   // Write cycles; the command address and codes here are a simplification.
   always @(posedge pins.weN) begin
      if (!pins.ceN) begin
         if (hvResetLevel) begin
            if (pins.dqOut[0]) prot[pins.addr[20:17]] = 1'b1;
            else if (prot.and() == 1'b1) foreach (prot[i]) prot[i] = 1'b0;
         end else if (pins.addr == 21'h555 && pins.dqOut[7:0] == 8'h90) cmdId = 1'b1;
         else if (pins.addr == 21'h555 && pins.dqOut[7:0] == 8'hf0) cmdId = 1'b0;
         else if (!prot[pins.addr[20:17]]) mem[int'(pins.addr)] = pins.dqOut;
      end
   end
endmodule

// *** bench/tb.sv ***
// Self-checking bench for the flash identification and protection controller.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import fap_pkg::*;
   localparam logic [7:0] MC = 8'h5c; // Arbitrary identity value.
   localparam logic [7:0] D1 = 8'h3d; // Arbitrary identity value.
   localparam logic [7:0] D2 = 8'h47; // Arbitrary identity value.
   localparam logic [7:0] D3 = 8'h29; // Arbitrary identity value.
   localparam logic [7:0] UP = 8'h6b; // Arbitrary identity value.
   localparam logic [3:0] SELS [6] = '{4'h0, 4'h1, 4'he, 4'hf, 4'h2, 4'h3};
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = '0;
   logic [31:0] hwdata = '0;
   logic [1:0] htrans = '0;
   logic [2:0] hsize = '0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic hvIdLevel;
   logic hvResetLevel;
   logic [15:0] dqIn;
   logic [20:0] lastAddr;
   logic lastHv;
   fap_pins_s flashPins;
   int errors = 0;
   int checks_done = 0;
   int cycles = 0;
   int unsigned rng = 31374;
   logic expProt [16];
   logic [15:0] expMem [int];
   logic [31:0] d;

   // Free-running 125 MHz clock.
   always #4 core_clk = ~core_clk;

   fap_host_ctrl u_fap_host_ctrl (.core_clk(core_clk), .resetn(resetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .dqIn(dqIn), .flashPins(flashPins), .hvIdLevel(hvIdLevel),
      .hvResetLevel(hvResetLevel));

   fap_flash_model #(.MANUF_CODE(MC), .DEV1_CODE(D1), .DEV2_CODE(D2), .DEV3_CODE(D3),
      .UPPER_CODE(UP), .TOP_BOOT(1'b1), .LOCKED(1'b1)) u_fap_flash_model (
      .pins(flashPins), .hvIdLevel(hvIdLevel), .hvResetLevel(hvResetLevel), .dqIn(dqIn),
      .lastAddr(lastAddr), .lastHv(lastHv));

   function automatic int unsigned xrand();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction

   // Expected identification word from the bench's own view of the part.
   function automatic logic [15:0] expId(int item, logic bm, logic p);
      logic [7:0] lo;
      case (item)
         0: lo = MC;
         1: lo = D1;
         2: lo = D2;
         3: lo = D3;
         4: lo = {7'h0, p};
         default: lo = 8'h98;
      endcase
      return {((bm || item > 3) ? 8'h00 : UP), lo};
   endfunction

   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   // A hang anywhere ends the run through the common report.
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 60000) begin
         errors++;
         $display("BAD timeout expected done seen hang");
         test_done();
      end
   end

   // One AHB-Lite single word transfer; entered just after a rising edge.
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      hsize <= 3'b010;
      htrans <= 2'b10;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      rd = hrdata;
      chk("hresp", 32'h0, 32'(hresp));
   endtask

   // One flash operation: set up, start, wait for busy to clear, fetch the result.
   task automatic fop(input logic [1:0] op, input int item, input logic hv, input logic rst,
                      input logic bm, input logic [21:0] a, input logic [15:0] wd,
                      output logic [31:0] rd);
      logic [31:0] c;
      int n;
      c = '0;
      c[CTRL_START] = 1'b1;
      c[CTRL_OP_LO+:2] = op;
      c[CTRL_HV_ID] = hv;
      c[CTRL_HV_RST] = rst;
      c[CTRL_BYTE] = bm;
      c[CTRL_ITEM_LO+:3] = 3'(item);
      ahb(1'b1, OFS_ADDR, {10'h0, a}, rd);
      ahb(1'b1, OFS_WDATA, {16'h0, wd}, rd);
      ahb(1'b1, OFS_CTRL, c, rd);
      repeat (3) @(posedge core_clk);
      n = 0;
      do begin
         ahb(1'b0, OFS_STATUS, '0, rd);
         n++;
      end while (rd[ST_BUSY] !== 1'b0 && n < 200);
      chk("busy", 32'h0, 32'(rd[ST_BUSY]));
      ahb(1'b0, OFS_RDATA, '0, rd);
   endtask

   // Program and read back one random word of a group, then one byte of it.
   task automatic arr(int g);
      logic [20:0] wa;
      logic [15:0] v;
      logic [31:0] r;
      wa = {4'(g), 17'(xrand()) | 17'h01000};
      v = 16'(xrand());
      fop(2'd2, 0, 1'b0, 1'b0, 1'b0, {wa, 1'b0}, v, r);
      if (!expProt[g]) expMem[int'(wa)] = v;
      v = expMem.exists(int'(wa)) ? expMem[int'(wa)] : 16'hffff;
      fop(2'd1, 0, 1'b0, 1'b0, 1'b0, {wa, 1'b0}, 16'h0, r);
      chk("array", {16'h0, v}, r);
      fop(2'd1, 0, 1'b0, 1'b0, 1'b1, {wa, 1'b1}, 16'h0, r);
      chk("array byte", {24'h0, v[15:8]}, r);
   endtask

   // Main sequence.
   initial begin
      int s;
      int g;
      foreach (expProt[i]) expProt[i] = 1'b0;
      repeat (4) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
      ahb(1'b0, OFS_STATUS, '0, d);
      chk("status", 32'h0, d);
      ahb(1'b1, 8'h20, 32'hffffffff, d);
      ahb(1'b0, 8'h20, '0, d);
      chk("unmapped", 32'h0, d);
      // A reserved op code with start set must never launch a flash cycle.
      ahb(1'b1, OFS_CTRL, 32'h00000007, d);
      repeat (3) @(posedge core_clk);
      ahb(1'b0, OFS_STATUS, '0, d);
      chk("reserved op", 32'h0, d);
      ahb(1'b0, OFS_CTRL, '0, d);
      chk("ctrl", 32'h6, d);
      for (int bm = 0; bm < 2; bm++) begin
         for (int it = 0; it < 6; it++) begin
            s = int'(xrand() % 512);
            fop(2'd0, it, 1'b1, 1'b0, 1'(bm), {9'(s), 13'h0}, 16'h0, d);
            chk("id", {16'h0, expId(it, 1'(bm), expProt[s >> 5])}, d);
            chk("id select", {27'h0, 1'b0, SELS[it]},
                {27'h0, lastAddr[6], lastAddr[3:0]});
            chk("id level", 32'h1, 32'(lastHv));
         end
      end
      ahb(1'b0, OFS_STATUS, '0, d);
      chk("lock flag", 32'h1, 32'(d[ST_LOCK]));
      fop(2'd2, 0, 1'b0, 1'b0, 1'b0, 22'h000aaa, 16'h0090, d);
      fop(2'd0, 1, 1'b0, 1'b0, 1'b0, 22'h0, 16'h0, d);
      chk("cmd id", {16'h0, UP, D1}, d);
      chk("cmd level", 32'h0, 32'(lastHv));
      fop(2'd2, 0, 1'b0, 1'b0, 1'b0, 22'h000aaa, 16'h00f0, d);
      g = int'(xrand() % 16);
      fop(2'd2, 0, 1'b0, 1'b1, 1'b0, {4'(g), 18'h0}, 16'h0001, d);
      expProt[g] = 1'b1;
      for (int k = 0; k < 4; k++) begin
         fop(2'd0, 4, 1'b1, 1'b0, 1'b0, {4'(g), 2'(k), 16'h0}, 16'h0, d);
         chk("group prot", 32'h1, d);
      end
      ahb(1'b0, OFS_STATUS, '0, d);
      chk("prot flag", 32'h1, 32'(d[ST_PROT]));
      fop(2'd0, 4, 1'b1, 1'b0, 1'b0, {4'(g ^ 1), 18'h0}, 16'h0, d);
      chk("other group", 32'h0, d);
      arr(g);
      arr(g ^ 1);
      for (int q = 0; q < 16; q++) begin
         if (!expProt[q]) fop(2'd2, 0, 1'b0, 1'b1, 1'b0, {4'(q), 18'h0}, 16'h0001, d);
         expProt[q] = 1'b1;
      end
      fop(2'd2, 0, 1'b0, 1'b1, 1'b0, 22'h0, 16'h0000, d);
      foreach (expProt[i]) expProt[i] = 1'b0;
      fop(2'd0, 4, 1'b1, 1'b0, 1'b0, {4'(g), 18'h0}, 16'h0, d);
      chk("unprotected", 32'h0, d);
      arr(g);
      test_done();
   end
endmodule
